// >>> include/dpt_pkg.sv
/*
 * Package for the dual prescaled counter/timer: register offsets,
 * field positions, reset values and mode encodings.
 * Assumes a 32-bit AHB-Lite register bus, one register per word.
 */
`default_nettype none
package dpt_pkg;
    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] DPT_OFS_CTRL     = 8'h00;
    localparam logic [7:0] DPT_OFS_C0_INIT  = 8'h04;
    localparam logic [7:0] DPT_OFS_C0_PRE   = 8'h08;
    localparam logic [7:0] DPT_OFS_C1_INIT  = 8'h0C;
    localparam logic [7:0] DPT_OFS_C1_PRE   = 8'h10;
    localparam logic [7:0] DPT_OFS_STATUS   = 8'h14;
    localparam logic [7:0] DPT_OFS_MASK     = 8'h18;
    localparam logic [7:0] DPT_OFS_EXTCFG   = 8'h1C;
    // ----------------------------------------
    // CTRL fields (per timer n: base 4*n)
    // ----------------------------------------
    localparam int DPT_CTRL_RUN     = 0;
    localparam int DPT_CTRL_LOAD    = 1;
    localparam int DPT_CTRL_CONT    = 2;
    localparam int DPT_CTRL_STRIDE  = 4;
    // ----------------------------------------
    // EXTCFG fields
    // ----------------------------------------
    localparam int DPT_EXT_MODE_LSB = 0;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] DPT_INIT_RST = 8'h00;
    localparam logic [5:0] DPT_PRE_RST  = 6'h00;
    localparam logic [1:0] DPT_IRQ_RST  = 2'h0;
    typedef enum logic [1:0] {
        DPT_EXT_INTERNAL = 2'b00,
        DPT_EXT_CLOCK    = 2'b01,
        DPT_EXT_GATE     = 2'b10,
        DPT_EXT_TRIGGER  = 2'b11
    } dpt_ext_mode_t;
endpackage
`default_nettype wire

// >>> hw/dpt_sync.sv
/*
 * Two-stage synchroniser with rising/falling edge detection.
 * Assumes an asynchronous input and a single clock domain.
 */
`default_nettype none
module dpt_sync (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic async_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    assign level = s2_r;
    assign rise  = s2_r & ~s3_r;
    assign fall  = ~s2_r & s3_r;
endmodule
`default_nettype wire

// >>> hw/dpt_channel.sv
/*
 * One prescaler plus 8-bit down-counter.
 * Assumes tick_en qualifies each source clock and load is one cycle.
 */
`default_nettype none
module dpt_channel
    import dpt_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       tick_en,
    input  wire logic       run,
    input  wire logic       cont,
    input  wire logic       load,
    input  wire logic [7:0] init_val,
    input  wire logic [5:0] pre_val,
    output logic [7:0]      count,
    output logic            eoc,
    output logic            running
);
    logic [5:0] pre_r;
    logic [5:0] pre_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       act_r;
    logic       act_nxt;
    logic       eoc_nxt;
    logic       eoc_r;
    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        pre_nxt = pre_r;
        cnt_nxt = cnt_r;
        act_nxt = act_r & run;
        eoc_nxt = 1'b0;
        if (load) begin
            pre_nxt = pre_val - 6'd1;
            cnt_nxt = init_val;
            act_nxt = run;
        end else if (act_r && run && tick_en) begin
            if (pre_r == 6'd0) begin
                pre_nxt = pre_val - 6'd1;
                cnt_nxt = cnt_r - 8'd1;
                if (cnt_r == 8'd1) begin
                    eoc_nxt = 1'b1;
                    if (cont) begin
                        cnt_nxt = init_val;
                    end else begin
                        cnt_nxt = 8'd0;
                        act_nxt = 1'b0;
                    end
                end
            end else begin
                pre_nxt = pre_r - 6'd1;
            end
        end else if (run && !act_r && cnt_r != 8'd0) begin
            act_nxt = 1'b1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_r <= DPT_PRE_RST;
            cnt_r <= DPT_INIT_RST;
            act_r <= 1'b0;
            eoc_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            act_r <= act_nxt;
            eoc_r <= eoc_nxt;
        end
    end
    assign count   = cnt_r;
    assign eoc     = eoc_r;
    assign running = act_r;
endmodule
`default_nettype wire

// >>> hw/dpt_top.sv
/*
 * Dual prescaled counter/timer with AHB-Lite register slave.
 * Assumes a single hclk domain; the external timer input is asynchronous.
 */
// Chosen here: the address map and the AHB-Lite interface to the registers.
`default_nettype none
// Notes on behaviour
// - Two independent 8-bit counters, each with its own prescaler.
// - Only the second timer may take the external clock; the first uses the internal one.
// - Each prescaler divides its source by 1 to 64 (value 0 means 64).
// - Each counter decrements once per prescaler pulse from an initial 1 to 256.
// - End of count raises first_timer_irq or second_timer_irq respectively.
// - Software can start, stop, resume or restart each counter from its initial value.
// - Single-pass mode halts at zero; continuous mode reloads and keeps counting.
// - Reading a counter returns its current value without disturbing it; prescalers are unreadable.
// - The second timer's external input acts as retrigger, non-retrigger trigger or gate.
// - A port input line serves as the external timer input driven by the outside party.
// - Writing a counter register sets its initial value; reading returns the current count.
// - Initial value 01 means a count of 1 and 00 means 256.
// - The external input comes from the first analog input line.
module dpt_top
    import dpt_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        first_analog_input,
    output logic             first_timer_irq,
    output logic             second_timer_irq,
    output logic             irq
);
    // ----------------------------------------
    // Bus address phase capture
    // ----------------------------------------
    logic       wr_pend_r;
    logic       wr_pend_nxt;
    logic [7:0] wr_addr_r;
    logic [7:0] wr_addr_nxt;
    logic       addr_ok;
    logic       rd_now;

    function automatic logic is_reg(input logic [7:0] a);
        is_reg = (a[1:0] == 2'b00) && (a <= DPT_OFS_EXTCFG);
    endfunction

    assign addr_ok = hsel & hready & htrans[1];
    assign rd_now  = addr_ok & ~hwrite;

    always_comb begin
        wr_pend_nxt = addr_ok & hwrite & is_reg(haddr[7:0]);
        wr_addr_nxt = addr_ok ? haddr[7:0] : wr_addr_r;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
        end
    end

    function automatic logic wr_hit(input logic [7:0] ofs, input logic pend,
                                    input logic [7:0] a);
        wr_hit = pend && (a == ofs);
    endfunction

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] init_r [2];
    logic [7:0] init_nxt [2];
    logic [5:0] pre_r [2];
    logic [5:0] pre_nxt [2];
    logic [1:0] mask_r;
    logic [1:0] mask_nxt;
    logic [1:0] ext_r;
    logic [1:0] ext_nxt;
    logic [1:0] load_p;
    logic [7:0] ofs_init [2];
    logic [7:0] ofs_pre [2];

    assign ofs_init[0] = DPT_OFS_C0_INIT;
    assign ofs_init[1] = DPT_OFS_C1_INIT;
    assign ofs_pre[0]  = DPT_OFS_C0_PRE;
    assign ofs_pre[1]  = DPT_OFS_C1_PRE;

    always_comb begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        ext_nxt  = ext_r;
        load_p   = 2'b00;
        for (int n = 0; n < 2; n++) begin
            init_nxt[n] = init_r[n];
            pre_nxt[n]  = pre_r[n];
            if (wr_hit(ofs_init[n], wr_pend_r, wr_addr_r)) begin
                init_nxt[n] = hwdata[7:0];
            end
            if (wr_hit(ofs_pre[n], wr_pend_r, wr_addr_r)) begin
                pre_nxt[n] = hwdata[5:0];
            end
        end
        if (wr_hit(DPT_OFS_CTRL, wr_pend_r, wr_addr_r)) begin
            ctrl_nxt = hwdata[7:0];
            for (int n = 0; n < 2; n++) begin
                load_p[n] = hwdata[n*DPT_CTRL_STRIDE + DPT_CTRL_LOAD];
            end
            ctrl_nxt[DPT_CTRL_LOAD] = 1'b0;
            ctrl_nxt[DPT_CTRL_STRIDE + DPT_CTRL_LOAD] = 1'b0;
        end
        if (wr_hit(DPT_OFS_MASK, wr_pend_r, wr_addr_r)) begin
            mask_nxt = hwdata[1:0];
        end
        if (wr_hit(DPT_OFS_EXTCFG, wr_pend_r, wr_addr_r)) begin
            ext_nxt = hwdata[DPT_EXT_MODE_LSB +: 2];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= 8'h00;
            mask_r <= DPT_IRQ_RST;
            ext_r  <= DPT_EXT_INTERNAL;
            for (int n = 0; n < 2; n++) begin
                init_r[n] <= DPT_INIT_RST;
                pre_r[n]  <= DPT_PRE_RST;
            end
        end else begin
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
            ext_r  <= ext_nxt;
            for (int n = 0; n < 2; n++) begin
                init_r[n] <= init_nxt[n];
                pre_r[n]  <= pre_nxt[n];
            end
        end
    end

    // ----------------------------------------
    // External timer input
    // ----------------------------------------
    logic ext_lvl;
    logic ext_rise;
    logic ext_fall;
    dpt_sync u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (first_analog_input),
        .level    (ext_lvl),
        .rise     (ext_rise),
        .fall     (ext_fall)
    );

    // Trigger: falling edge loads; retrigger when ctrl bit 7 is set
    logic       trig_load;
    logic [1:0] tick_en;
    logic [1:0] run;
    logic [1:0] running;
    logic [1:0] eoc;
    logic [7:0] count [2];
    logic       retrig;

    assign retrig    = ctrl_r[7];
    assign trig_load = (ext_r == DPT_EXT_TRIGGER) && ext_fall
                       && (retrig || !running[1]);
    always_comb begin
        tick_en[0] = 1'b1;
        case (ext_r)
            DPT_EXT_CLOCK:   tick_en[1] = ext_fall;
            DPT_EXT_GATE:    tick_en[1] = ext_lvl;
            default:         tick_en[1] = 1'b1;
        endcase
    end

    // ----------------------------------------
    // Counter channels
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            // Run follows the written value so start and restart act together
            assign run[g] = ctrl_nxt[g*DPT_CTRL_STRIDE + DPT_CTRL_RUN];
            dpt_channel u_ch (
                .hclk     (hclk),
                .hresetn  (hresetn),
                .tick_en  (tick_en[g]),
                .run      (run[g]),
                .cont     (ctrl_r[g*DPT_CTRL_STRIDE + DPT_CTRL_CONT]),
                .load     (load_p[g] | (g == 1 ? trig_load : 1'b0)),
                .init_val (init_r[g]),
                .pre_val  (pre_r[g]),
                .count    (count[g]),
                .eoc      (eoc[g]),
                .running  (running[g])
            );
        end
    endgenerate
    logic unused_rise;
    assign unused_rise = ext_rise;

    // ----------------------------------------
    // Interrupt status, set wins over clear
    // ----------------------------------------
    logic [1:0] stat_r;
    logic [1:0] stat_nxt;
    always_comb begin
        stat_nxt = stat_r;
        if (wr_hit(DPT_OFS_STATUS, wr_pend_r, wr_addr_r)) begin
            stat_nxt = stat_r & ~hwdata[1:0];
        end
        stat_nxt = stat_nxt | eoc;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_r <= DPT_IRQ_RST;
        end else begin
            stat_r <= stat_nxt;
        end
    end
    assign first_timer_irq  = stat_r[0];
    assign second_timer_irq = stat_r[1];
    assign irq = |(stat_r & mask_r);

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (rd_now) begin
            case (haddr[7:0])
                DPT_OFS_CTRL:    rdata_nxt[7:0] = ctrl_r;
                DPT_OFS_C0_INIT: rdata_nxt[7:0] = count[0];
                DPT_OFS_C1_INIT: rdata_nxt[7:0] = count[1];
                DPT_OFS_STATUS:  rdata_nxt[1:0] = stat_r;
                DPT_OFS_MASK:    rdata_nxt[1:0] = mask_r;
                DPT_OFS_EXTCFG:  rdata_nxt[1:0] = ext_r;
                default:         rdata_nxt = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end
    assign hrdata    = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
endmodule
`default_nettype wire

// >>> sim/dpt_top_sva.sv
/*
 * Port checker for dpt_top: bus answer, read data, interrupt lines.
 * Assumes it is bound to dpt_top, one hclk domain.
 */
`default_nettype none
module dpt_top_sva
    import dpt_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        first_timer_irq,
    input wire logic        second_timer_irq,
    input wire logic        irq
);
    // ------------------------------
    // Taken transfers
    // ------------------------------
    logic       rd_now;
    logic [2:0] wr_hist_r;
    logic [2:0] wr_hist_nxt;
    assign rd_now = hsel && hready && htrans[1] && !hwrite;
    always_comb begin
        wr_hist_nxt = {wr_hist_r[1:0], hsel && hready && htrans[1] && hwrite};
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_hist_r <= 3'h0;
        end else begin
            wr_hist_r <= wr_hist_nxt;
        end
    end
    // ------------------------------
    // Properties
    // ------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_pre;
        rd_now && (haddr[7:0] == DPT_OFS_C0_PRE || haddr[7:0] == DPT_OFS_C1_PRE);
    endsequence
    sequence rd_hole;
        rd_now && haddr >= 32'h0000_0020 && haddr <= 32'h0000_00FC;
    endsequence
    AST_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    AST_RD_IDLE: assert property (hrdata != 32'h0000_0000 |-> $past(rd_now))
        else $error("read data outside a read data phase");
    AST_RD_WIDTH: assert property (rd_now |=> hrdata[31:8] == 24'h00_0000)
        else $error("read data wider than eight bits");
    AST_PRE_HIDDEN: assert property (rd_pre |=> hrdata == 32'h0000_0000)
        else $error("prescaler value readable");
    AST_HOLE: assert property (rd_hole |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_IRQ_SRC: assert property (irq |-> first_timer_irq || second_timer_irq)
        else $error("irq without a timer request");
    AST_IRQ0_HOLD: assert property ($fell(first_timer_irq) |-> wr_hist_r != 3'h0)
        else $error("first timer request dropped without a write");
    AST_IRQ1_HOLD: assert property ($fell(second_timer_irq) |-> wr_hist_r != 3'h0)
        else $error("second timer request dropped without a write");
endmodule
bind dpt_top dpt_top_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .first_timer_irq(first_timer_irq),
    .second_timer_irq(second_timer_irq), .irq(irq));
`default_nettype wire

// >>> sim/dpt_ext_model.sv
/*
 * External timer input source for the second timer.
 * Assumes pulse requests last one hclk cycle, at least 8 cycles apart.
 */
`default_nettype none
module dpt_ext_model (
    input  wire logic hclk,
    input  wire logic pulse_req,
    input  wire logic gate_lvl,
    output logic      first_analog_input
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] low_cnt_r = 3'h0;
    // Low phase of four clocks per pulse
    always @(posedge hclk) begin
        if (pulse_req && low_cnt_r == 3'h0) begin
            low_cnt_r <= 3'h4;
        end else if (low_cnt_r != 3'h0) begin
            low_cnt_r <= low_cnt_r - 3'h1;
        end
    end
    // Gate level outside pulses
    assign first_analog_input = gate_lvl && (low_cnt_r == 3'h0);
endmodule
`default_nettype wire

// >>> sim/dpt_top_tb.sv
/*
 * Self-checking bench for dpt_top over AHB-Lite.
 * Assumes a zero-wait slave and dpt_ext_model on the timer input.
 */
`default_nettype none
module dpt_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dpt_pkg::*;
    localparam logic [31:0] Z = 32'h0000_0000;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = Z;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = Z;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        ext_in;
    logic        c0_irq;
    logic        c1_irq;
    logic        irq;
    logic        pulse_req = 1'b0;
    logic        gate_lvl = 1'b1;
    logic [31:0] rd;
    logic [31:0] c;
    logic [7:0]  pv [4] = '{8'h01, 8'h00, 8'h03, 8'h01};
    logic [7:0]  iv [4] = '{8'h01, 8'h01, 8'h02, 8'h00};
    int          per [4] = '{1, 64, 6, 256};
    int          err_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          k;
    dpt_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .first_analog_input(ext_in),
        .first_timer_irq(c0_irq), .second_timer_irq(c1_irq), .irq(irq));
    dpt_ext_model ext (.hclk(hclk), .pulse_req(pulse_req), .gate_lvl(gate_lvl),
        .first_analog_input(ext_in));
    always #12.5 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    // ------------------------------
    // Bus and check tasks
    // ------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic rng(input logic [31:0] v, input int lo, input int hi, input string s);
        chk({31'h0, v >= lo && v <= hi}, 32'h0000_0001, s);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string s);
        xfer(1'b0, a, Z);
        chk(rd, e, s);
    endtask
    task automatic wait_irq(input logic sel, input int lim, output int n);
        n = 0;
        while (n < lim && (sel ? c1_irq : c0_irq) !== 1'b1) begin
            @(posedge hclk);
            n++;
        end
    endtask
    task automatic pulse;
        pulse_req <= 1'b1;
        @(posedge hclk);
        pulse_req <= 1'b0;
        repeat (10) @(posedge hclk);
    endtask
    task automatic final_report;
        $display("Checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ------------------------------
    // Tests
    // ------------------------------
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(DPT_OFS_C0_INIT, Z, "c0 reset");
        rchk(DPT_OFS_STATUS, Z, "status reset");
        wr(8'h24, 32'h0000_00FF);
        rchk(8'h24, Z, "unmapped");
        wr(DPT_OFS_C0_PRE, 32'h0000_0004);
        rchk(DPT_OFS_C0_PRE, Z, "pre hidden");
        wr(DPT_OFS_C0_INIT, Z);
        wr(DPT_OFS_CTRL, 32'h0000_0003);
        repeat (40) @(posedge hclk);
        wr(DPT_OFS_CTRL, Z);
        xfer(1'b0, DPT_OFS_C0_INIT, Z);
        c = rd;
        rng(c, 240, 254, "count from 256");
        repeat (20) @(posedge hclk);
        rchk(DPT_OFS_C0_INIT, c, "stopped read");
        wr(DPT_OFS_CTRL, 32'h0000_0001);
        repeat (40) @(posedge hclk);
        wr(DPT_OFS_CTRL, Z);
        xfer(1'b0, DPT_OFS_C0_INIT, Z);
        rng(rd, c - 13, c - 8, "resume");
        wr(DPT_OFS_C0_INIT, 32'h0000_0005);
        wr(DPT_OFS_CTRL, 32'h0000_0002);
        rchk(DPT_OFS_C0_INIT, 32'h0000_0005, "restart");
        $display("Test control done");
        for (int i = 0; i < 4; i++) begin
            wr(DPT_OFS_STATUS, 32'h0000_0003);
            wr(DPT_OFS_C0_PRE, 32'(pv[i]));
            wr(DPT_OFS_C0_INIT, 32'(iv[i]));
            wr(DPT_OFS_CTRL, 32'h0000_0003);
            wait_irq(1'b0, 400, k);
            rng(k, per[i] - 1, per[i] + 4, "end time");
            repeat (10) @(posedge hclk);
            rchk(DPT_OFS_C0_INIT, Z, "single pass");
        end
        chk(irq, 1'b0, "masked");
        wr(DPT_OFS_MASK, 32'h0000_0001);
        @(posedge hclk);
        chk(irq, 1'b1, "unmasked");
        wr(DPT_OFS_STATUS, 32'h0000_0001);
        rchk(DPT_OFS_STATUS, Z, "w1c");
        chk(irq, 1'b0, "cleared");
        wr(DPT_OFS_C0_INIT, 32'h0000_0004);
        wr(DPT_OFS_CTRL, 32'h0000_0007);
        wait_irq(1'b0, 20, k);
        wr(DPT_OFS_STATUS, 32'h0000_0001);
        @(posedge hclk);
        wait_irq(1'b0, 10, k);
        rng(k, 0, 9, "continuous");
        $display("Test first timer done");
        wr(DPT_OFS_EXTCFG, 32'h0000_0001);
        wr(DPT_OFS_C1_PRE, 32'h0000_0001);
        wr(DPT_OFS_C1_INIT, 32'h0000_0002);
        wr(DPT_OFS_STATUS, 32'h0000_0003);
        wr(DPT_OFS_CTRL, 32'h0000_0030);
        repeat (30) @(posedge hclk);
        pulse();
        rchk(DPT_OFS_C1_INIT, 32'h0000_0001, "ext clock");
        pulse();
        wait_irq(1'b1, 12, k);
        chk(c1_irq, 1'b1, "ext end");
        wr(DPT_OFS_EXTCFG, 32'h0000_0002);
        gate_lvl <= 1'b0;
        wr(DPT_OFS_STATUS, 32'h0000_0003);
        wr(DPT_OFS_CTRL, 32'h0000_0030);
        repeat (30) @(posedge hclk);
        rchk(DPT_OFS_C1_INIT, 32'h0000_0002, "gate low");
        gate_lvl <= 1'b1;
        wait_irq(1'b1, 20, k);
        chk(c1_irq, 1'b1, "gate high");
        wr(DPT_OFS_EXTCFG, 32'h0000_0003);
        wr(DPT_OFS_C1_PRE, 32'h0000_0004);
        wr(DPT_OFS_C1_INIT, 32'h0000_0010);
        wr(DPT_OFS_CTRL, 32'h0000_0090);
        pulse();
        xfer(1'b0, DPT_OFS_C1_INIT, Z);
        rng(rd, 13, 16, "trigger");
        pulse();
        xfer(1'b0, DPT_OFS_C1_INIT, Z);
        rng(rd, 14, 16, "retrigger");
        wr(DPT_OFS_CTRL, 32'h0000_0010);
        pulse();
        xfer(1'b0, DPT_OFS_C1_INIT, Z);
        rng(rd, 9, 12, "no retrigger");
        $display("Test second timer done");
        final_report();
    end
endmodule
`default_nettype wire
